// File: dbu_pkg.sv
// Package: register map, field positions, reset values and modes of the debug serial port
`default_nettype none
package dbu_pkg;
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_MODE = 12'h004;
  localparam logic [11:0] OFF_IEN = 12'h008;
  localparam logic [11:0] OFF_IDIS = 12'h00C;
  localparam logic [11:0] OFF_IMASK = 12'h010;
  localparam logic [11:0] OFF_STAT = 12'h014;
  localparam logic [11:0] OFF_RHR = 12'h018;
  localparam logic [11:0] OFF_THR = 12'h01C;
  localparam logic [11:0] OFF_BAUD = 12'h020;
  localparam logic [11:0] OFF_ID = 12'h040;
  localparam logic [11:0] OFF_IDX = 12'h044;
  localparam logic [11:0] OFF_DPB = 12'h048;
  localparam logic [11:0] OFF_XFER_BASE = 12'h100;
  // Command bits
  localparam int CMD_RXRST = 2;
  localparam int CMD_TXRST = 3;
  localparam int CMD_RXON = 4;
  localparam int CMD_RXOFF = 5;
  localparam int CMD_TXON = 6;
  localparam int CMD_TXOFF = 7;
  localparam int CMD_ECLR = 8;
  // Mode fields
  localparam int MODE_PAR_LSB = 9;
  localparam int MODE_CH_LSB = 14;
  localparam logic [31:0] MODE_MASK = 32'h0000_CE00;
  // Shared status / interrupt layout
  localparam int ST_RECEIVE_CHAR_AVAILABLE = 0;
  localparam int ST_TRANSMIT_HOLDING_FREE = 1;
  localparam int ST_RXEND = 3;
  localparam int ST_TXEND = 4;
  localparam int ST_OVR = 5;
  localparam int ST_FRM = 6;
  localparam int ST_PAR = 7;
  localparam int ST_TRANSMITTER_IDLE_FLAG = 9;
  localparam int ST_TRANSMIT_BUFFER_DRAINED = 11;
  localparam int ST_RECEIVE_BUFFER_FILLED = 12;
  localparam int ST_DCW = 30;
  localparam int ST_DCR = 31;
  localparam logic [31:0] IRQ_MASK = 32'hC000_1AFB;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] IMASK_RESET = 32'h0000_0000;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [7:0] RHR_RESET = 8'h00;
  localparam int OVS = 16;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] DATA_BITS = 4'h8;
  typedef enum logic [1:0] {CH_NORMAL = 2'b00, CH_ECHO = 2'b01, CH_LOCAL = 2'b10, CH_REMOTE = 2'b11} dbu_channel_test_select_e;
  typedef enum logic [2:0] {
    LN_IDLE = 3'b000, LN_START = 3'b001, LN_DATA = 3'b010, LN_PAR = 3'b011, LN_STOP = 3'b100
  } dbu_line_e;
endpackage
`default_nettype wire

// File: dbu_term.sv
// Remote serial terminal on the far side of the line
`default_nettype none
module dbu_term (
  input wire logic pclk,
  input wire logic tx_pin,
  output var logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Divisor 1 gives sixteen clocks a bit
  localparam int BIT = 16;
  logic [8:0] got [$];
  logic [8:0] sh;
  initial rx_pin = 1'b1;
  // Trailing idle bit lets frames follow back to back
  task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic stp);
    logic [11:0] fr;
    fr = pe ? {1'b1, stp, pb, d, 1'b0} : {2'b11, stp, d, 1'b0};
    for (int i = 0; i < 12; i++)
    begin
      rx_pin <= fr[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask
  always
  begin
    @(negedge tx_pin);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge pclk);
      sh[i] = tx_pin;
    end
    got.push_back(sh);
  end
endmodule // dbu_term
`default_nettype wire

// File: dbu_uart.sv
// Debug serial port: APB register file, receiver, transmitter, test modes
`default_nettype none
// What this block does
// - Receiver reset command resets, disables receiver, aborts any character in progress.
// - Transmitter reset command resets, disables transmitter, aborts character being shifted.
// - Receiver enable command takes effect only when receiver disable is zero.
// - Receiver disable without reset finishes the current character, then stops.
// - Transmitter enable command takes effect only when transmitter disable is zero.
// - Transmitter disable without reset drains shift and holding characters first.
// - Error clear command clears parity, framing and overrun flags only.
// - Check bit type: even, odd, space, mark, none when top bit set.
// - Channel select: normal, echo, local loopback, remote loopback.
// - Interrupt enable writes set mask bits where ones are written.
// - Interrupt disable writes clear mask bits where ones are written.
// - Mask register reads enabled sources, resets to zero.
// - Enable, disable, mask and status share one bit layout.
// - Receive ready shows an unread received character, zero when receiver off.
// - Transmit ready shows holding register free, zero when transmitter off.
// - Transmitter idle when holding and shift both empty and enabled.
// - Overrun, framing and parity flags are sticky until error clear.
// - Transfer done bits mirror transfer controller end signals.
// - Buffer drained and filled bits mirror transfer controller signals.
// - Top status bits mirror debug channel write and read pending.
// - Baud divisor at 0x20 resets to zero; transfer controller area from 0x100.
// - Reading receive holding register returns character and clears receive ready.
// - Debug port block forces test port reset low, else follows debug reset.
module dbu_uart #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] ID_EXT_VALUE = 32'h0000_0000 // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic receive_transfer_done,
  input wire logic transmit_transfer_done,
  input wire logic transmit_buffer_drained,
  input wire logic receive_buffer_filled,
  input wire logic debug_channel_write_pending,
  input wire logic debug_channel_read_pending,
  input wire logic debug_reset_n,
  output logic test_port_reset_n,
  output logic irq
);
  typedef struct packed {
    logic [1:0] rxs;
    logic [1:0] ext_s;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_pin;
    logic tpr_n;
    logic irq;
    logic [31:0] mode;
    logic [31:0] imask;
    logic [15:0] baud;
    logic dpb;
    logic rx_en;
    logic rx_stop;
    logic tx_en;
    logic tx_stop;
    logic rx_rdy;
    logic [7:0] rhr;
    logic ovr;
    logic frm;
    logic perr;
    logic [7:0] thr;
    logic thr_full;
    logic [15:0] bcnt;
    logic btick;
    dbu_pkg::dbu_line_e rst;
    logic [3:0] rph;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rpar;
    dbu_pkg::dbu_line_e tst;
    logic [3:0] tph;
    logic [3:0] tbit;
    logic [7:0] tsh;
    logic [7:0] tchr;
    logic tline;
  } dbu_state_s;

  dbu_state_s q;
  dbu_state_s d;

  logic [31:0] status;
  logic wr;
  logic rd;
  logic [2:0] partype;
  logic par_on;
  logic rx_in;
  logic rx_fall;
  logic [1:0] ch;
  logic [31:0] rdv;
  logic [7:0] parity_src;
  logic [2:0] err_set;

  // Parity bit for a given character under the selected type
  function automatic logic calc_par(input logic [2:0] pt, input logic [7:0] v);
    logic r;
    r = 1'b0;
    unique case (pt[1:0])
      2'b00: r = ^v;
      2'b01: r = ~(^v);
      2'b10: r = 1'b0;
      2'b11: r = 1'b1;
    endcase
    return r;
  endfunction

  always_comb
  begin
    ch = q.mode[dbu_pkg::MODE_CH_LSB +: 2];
    partype = q.mode[dbu_pkg::MODE_PAR_LSB +: 3];
    par_on = ~partype[2];
    wr = psel & penable & pwrite & ~q.pready;
    rd = psel & penable & ~pwrite & ~q.pready;
    // Line source for the receiver depends on the test mode
    rx_in = (ch == dbu_pkg::CH_LOCAL) ? q.tline : q.rxs[1];
    // Only a falling edge starts a frame, so a low stop bit cannot restart it
    rx_fall = q.ext_s[0] & ~rx_in;
    parity_src = q.rsh;
    err_set = 3'b000;
    status = 32'h0000_0000;
    status[dbu_pkg::ST_RECEIVE_CHAR_AVAILABLE] = q.rx_rdy & q.rx_en;
    status[dbu_pkg::ST_TRANSMIT_HOLDING_FREE] = ~q.thr_full & q.tx_en;
    status[dbu_pkg::ST_TRANSMITTER_IDLE_FLAG] = ~q.thr_full & (q.tst == dbu_pkg::LN_IDLE) & q.tx_en;
    status[dbu_pkg::ST_RXEND] = receive_transfer_done;
    status[dbu_pkg::ST_TXEND] = transmit_transfer_done;
    status[dbu_pkg::ST_TRANSMIT_BUFFER_DRAINED] = transmit_buffer_drained;
    status[dbu_pkg::ST_RECEIVE_BUFFER_FILLED] = receive_buffer_filled;
    status[dbu_pkg::ST_OVR] = q.ovr;
    status[dbu_pkg::ST_FRM] = q.frm;
    status[dbu_pkg::ST_PAR] = q.perr;
    status[dbu_pkg::ST_DCW] = debug_channel_write_pending;
    status[dbu_pkg::ST_DCR] = debug_channel_read_pending;
    unique case (paddr)
      dbu_pkg::OFF_MODE: rdv = q.mode;
      dbu_pkg::OFF_IMASK: rdv = q.imask;
      dbu_pkg::OFF_STAT: rdv = status;
      dbu_pkg::OFF_RHR: rdv = {24'h000000, q.rhr};
      dbu_pkg::OFF_BAUD: rdv = {16'h0000, q.baud};
      dbu_pkg::OFF_ID: rdv = ID_VALUE;
      dbu_pkg::OFF_IDX: rdv = ID_EXT_VALUE;
      dbu_pkg::OFF_DPB: rdv = {31'h0000_0000, q.dpb};
      default: rdv = 32'h0000_0000;
    endcase

    d = q;
    d.rxs = {q.rxs[0], rx_pin};
    if (q.btick)
    begin
      d.ext_s = {q.ext_s[0], rx_in};
    end
    // One wait state: answer the cycle after penable rises
    d.pready = psel & penable & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata = rd ? rdv : 32'h0000_0000;

    // Baud tick at 16x oversampling; divisor of one gives the clock itself
    d.btick = 1'b0;
    if (q.baud == 16'h0000)
    begin
      d.bcnt = 16'h0000;
    end
    else if (q.bcnt >= q.baud - 16'h0001 || q.baud == 16'h0001)
    begin
      d.bcnt = 16'h0000;
      d.btick = 1'b1;
    end
    else
    begin
      d.bcnt = q.bcnt + 16'h0001;
    end

    // Receiver
    if (q.btick & q.rx_en & (ch != dbu_pkg::CH_REMOTE))
    begin
      unique case (q.rst)
        dbu_pkg::LN_IDLE:
        begin
          if (q.rx_stop)
          begin
            d.rx_en = 1'b0;
            d.rx_stop = 1'b0;
          end
          else if (rx_fall)
          begin
            d.rst = dbu_pkg::LN_START;
            d.rph = 4'h0;
          end
        end
        dbu_pkg::LN_START:
        begin
          d.rph = q.rph + 4'h1;
          if (q.rph == dbu_pkg::OVS_MID)
          begin
            d.rst = rx_in ? dbu_pkg::LN_IDLE : dbu_pkg::LN_DATA;
            d.rph = 4'h0;
            d.rbit = 4'h0;
          end
        end
        dbu_pkg::LN_DATA:
        begin
          d.rph = q.rph + 4'h1;
          if (q.rph == dbu_pkg::OVS_LAST)
          begin
            d.rsh = {rx_in, q.rsh[7:1]};
            d.rbit = q.rbit + 4'h1;
            if (q.rbit == dbu_pkg::DATA_BITS - 4'h1)
            begin
              d.rst = par_on ? dbu_pkg::LN_PAR : dbu_pkg::LN_STOP;
            end
          end
        end
        dbu_pkg::LN_PAR:
        begin
          d.rph = q.rph + 4'h1;
          if (q.rph == dbu_pkg::OVS_LAST)
          begin
            d.rpar = rx_in;
            d.rst = dbu_pkg::LN_STOP;
          end
        end
        dbu_pkg::LN_STOP:
        begin
          d.rph = q.rph + 4'h1;
          if (q.rph == dbu_pkg::OVS_LAST)
          begin
            d.rst = dbu_pkg::LN_IDLE;
            d.rhr = q.rsh;
            d.rx_rdy = 1'b1;
            if (q.rx_rdy)
            begin
              d.ovr = 1'b1;
              err_set[0] = 1'b1;
            end
            if (~rx_in)
            begin
              d.frm = 1'b1;
              err_set[1] = 1'b1;
            end
            if (par_on && (q.rpar != calc_par(partype, parity_src)))
            begin
              d.perr = 1'b1;
              err_set[2] = 1'b1;
            end
          end
        end
        default: d.rst = dbu_pkg::LN_IDLE;
      endcase
    end

    // Transmitter
    if (q.btick & q.tx_en)
    begin
      d.tph = q.tph + 4'h1;
      unique case (q.tst)
        dbu_pkg::LN_IDLE:
        begin
          d.tph = 4'h0;
          d.tline = 1'b1;
          if (q.thr_full)
          begin
            d.tsh = q.thr;
            d.tchr = q.thr;
            d.thr_full = 1'b0;
            d.tst = dbu_pkg::LN_START;
            d.tline = 1'b0;
          end
          else if (q.tx_stop)
          begin
            d.tx_en = 1'b0;
            d.tx_stop = 1'b0;
          end
        end
        dbu_pkg::LN_START:
        begin
          if (q.tph == dbu_pkg::OVS_LAST)
          begin
            d.tst = dbu_pkg::LN_DATA;
            d.tbit = 4'h0;
            d.tline = q.tsh[0];
          end
        end
        dbu_pkg::LN_DATA:
        begin
          if (q.tph == dbu_pkg::OVS_LAST)
          begin
            d.tbit = q.tbit + 4'h1;
            d.tsh = {1'b0, q.tsh[7:1]};
            if (q.tbit == dbu_pkg::DATA_BITS - 4'h1)
            begin
              d.tst = par_on ? dbu_pkg::LN_PAR : dbu_pkg::LN_STOP;
              d.tline = par_on ? calc_par(partype, q.tchr) : 1'b1;
            end
            else
            begin
              d.tline = q.tsh[1];
            end
          end
        end
        dbu_pkg::LN_PAR:
        begin
          if (q.tph == dbu_pkg::OVS_LAST)
          begin
            d.tst = dbu_pkg::LN_STOP;
            d.tline = 1'b1;
          end
        end
        dbu_pkg::LN_STOP:
        begin
          if (q.tph == dbu_pkg::OVS_LAST)
          begin
            d.tst = dbu_pkg::LN_IDLE;
          end
        end
        default: d.tst = dbu_pkg::LN_IDLE;
      endcase
    end

    // Register writes
    if (wr)
    begin
      unique case (paddr)
        dbu_pkg::OFF_CMD:
        begin
          if (pwdata[dbu_pkg::CMD_RXON] & ~pwdata[dbu_pkg::CMD_RXOFF])
          begin
            d.rx_en = 1'b1;
            d.rx_stop = 1'b0;
          end
          if (pwdata[dbu_pkg::CMD_RXOFF])
          begin
            if (q.rst == dbu_pkg::LN_IDLE)
            begin
              d.rx_en = 1'b0;
            end
            else
            begin
              d.rx_stop = 1'b1;
            end
          end
          if (pwdata[dbu_pkg::CMD_TXON] & ~pwdata[dbu_pkg::CMD_TXOFF])
          begin
            d.tx_en = 1'b1;
            d.tx_stop = 1'b0;
          end
          if (pwdata[dbu_pkg::CMD_TXOFF])
          begin
            if (q.tst == dbu_pkg::LN_IDLE && ~q.thr_full)
            begin
              d.tx_en = 1'b0;
            end
            else
            begin
              d.tx_stop = 1'b1;
            end
          end
          if (pwdata[dbu_pkg::CMD_RXRST])
          begin
            d.rx_en = 1'b0;
            d.rx_stop = 1'b0;
            d.rst = dbu_pkg::LN_IDLE;
            d.rx_rdy = 1'b0;
          end
          if (pwdata[dbu_pkg::CMD_TXRST])
          begin
            d.tx_en = 1'b0;
            d.tx_stop = 1'b0;
            d.tst = dbu_pkg::LN_IDLE;
            d.thr_full = 1'b0;
            d.tline = 1'b1;
          end
          if (pwdata[dbu_pkg::CMD_ECLR])
          begin
            // Clear yields to an error landing in the same cycle
            d.ovr = err_set[0];
            d.frm = err_set[1];
            d.perr = err_set[2];
          end
        end
        dbu_pkg::OFF_MODE: d.mode = pwdata & dbu_pkg::MODE_MASK;
        dbu_pkg::OFF_IEN: d.imask = q.imask | (pwdata & dbu_pkg::IRQ_MASK);
        dbu_pkg::OFF_IDIS: d.imask = q.imask & ~pwdata;
        dbu_pkg::OFF_THR:
        begin
          if (q.tx_en & ~q.tx_stop)
          begin
            d.thr = pwdata[7:0];
            d.thr_full = 1'b1;
          end
        end
        dbu_pkg::OFF_BAUD: d.baud = pwdata[15:0];
        dbu_pkg::OFF_DPB: d.dpb = pwdata[0];
        default: d.mode = q.mode;
      endcase
    end
    if (rd && paddr == dbu_pkg::OFF_RHR && !(d.rx_rdy && !q.rx_rdy))
    begin
      d.rx_rdy = 1'b0;
    end

    unique case (ch)
      dbu_pkg::CH_NORMAL: d.tx_pin = d.tline;
      dbu_pkg::CH_ECHO: d.tx_pin = q.rxs[1];
      dbu_pkg::CH_LOCAL: d.tx_pin = 1'b1;
      dbu_pkg::CH_REMOTE: d.tx_pin = q.rxs[1];
    endcase
    d.tpr_n = d.dpb ? 1'b0 : debug_reset_n;
    d.irq = |(status & q.imask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.rxs <= 2'b11;
      q.ext_s <= 2'b11;
      q.tx_pin <= 1'b1;
      q.tline <= 1'b1;
      q.tpr_n <= 1'b0;
      q.mode <= dbu_pkg::MODE_RESET;
      q.imask <= dbu_pkg::IMASK_RESET;
      q.baud <= dbu_pkg::BAUD_RESET;
      q.rhr <= dbu_pkg::RHR_RESET;
      q.rst <= dbu_pkg::LN_IDLE;
      q.tst <= dbu_pkg::LN_IDLE;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign tx_pin = q.tx_pin;
  assign test_port_reset_n = q.tpr_n;
  assign irq = q.irq;
endmodule // dbu_uart
`default_nettype wire

// File: dbu_uart_assertions.sv
// Port checker of the debug serial port
`default_nettype none
module dbu_uart_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_pin,
  input wire logic debug_channel_write_pending,
  input wire logic debug_channel_read_pending,
  input wire logic debug_reset_n,
  input wire logic test_port_reset_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_acc(logic w, logic [11:0] a);
    psel && penable && !pready && pwrite == w && paddr == a ##1 pready;
  endsequence
  a_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("answer not after one wait state");
  a_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_no_slverr: assert property (!pslverr)
    else $error("error response");
  a_status_layout: assert property (s_acc(1'b0, dbu_pkg::OFF_STAT) |->
    (prdata & ~dbu_pkg::IRQ_MASK) == 32'h0) else $error("status bit outside layout");
  a_mask_layout: assert property (s_acc(1'b0, dbu_pkg::OFF_IMASK) |->
    (prdata & ~dbu_pkg::IRQ_MASK) == 32'h0) else $error("mask bit outside layout");
  a_debug_mirror: assert property (s_acc(1'b0, dbu_pkg::OFF_STAT) |->
    prdata[31] == $past(debug_channel_read_pending) && prdata[30] == $past(debug_channel_write_pending))
    else $error("debug channel bits wrong");
  a_mode_rsvd: assert property (s_acc(1'b0, dbu_pkg::OFF_MODE) |->
    (prdata & ~dbu_pkg::MODE_MASK) == 32'h0) else $error("mode reserved bits set");
  a_rsvd_zero: assert property (psel && penable && !pready && !pwrite &&
    (paddr inside {[12'h024:12'h03C], [12'h04C:12'hFFF]}) ##1 pready |-> prdata == 32'h0)
    else $error("reserved offset not zero");
  a_port_block: assert property (s_acc(1'b1, dbu_pkg::OFF_DPB) ##0 pwdata[0] |-> ##[1:2] !test_port_reset_n)
    else $error("test reset not held low");
  a_port_follow: assert property (test_port_reset_n |-> $past(debug_reset_n))
    else $error("test reset high without debug reset");
  a_tx_abort: assert property (s_acc(1'b1, dbu_pkg::OFF_CMD) ##0
    (pwdata[dbu_pkg::CMD_TXRST] && !pwdata[dbu_pkg::CMD_TXON]) |-> ##2 tx_pin [*8])
    else $error("line not idle after transmitter reset");
endmodule // dbu_uart_chk
bind dbu_uart dbu_uart_chk u_chk (.*);
`default_nettype wire

// File: tb_debug_uart_register_interface.sv
// Self-checking bench of the debug serial port
`default_nettype none
module tb_debug_uart_register_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] ext = 6'h00;
  logic dbg_rst_n = 1'b1;
  logic [31:0] prdata, rd, mask, a, b;
  logic pready, pslverr, rx_pin, tx_pin, tprst_n, irq, f;
  logic [7:0] c;
  logic [2:0] p;
  logic [11:0] roff [6] = '{12'h004, 12'h010, 12'h014, 12'h018, 12'h020, 12'h048};
  logic [11:0] rsv [4] = '{12'h024, 12'h03C, 12'h04C, 12'h100};
  int n_mismatch = 0;
  int compares = 0;
  always #2.5 pclk = ~pclk;
  dbu_uart dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .receive_transfer_done(ext[0]), .transmit_transfer_done(ext[1]),
    .transmit_buffer_drained(ext[2]), .receive_buffer_filled(ext[3]), .debug_channel_write_pending(ext[4]),
    .debug_channel_read_pending(ext[5]), .debug_reset_n(dbg_rst_n), .test_port_reset_n(tprst_n), .irq(irq));
  dbu_term term (.pclk(pclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      n_mismatch++;
      finish_test();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdq(input logic [11:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic bits(input int n);
    repeat (16 * n) @(posedge pclk);
  endtask
  function automatic logic pbit(input logic [2:0] pt, input logic [7:0] d);
    pbit = pt[1] ? pt[0] : (^d ^ pt[0]);
  endfunction
  function automatic logic [31:0] ext_st(input logic [5:0] e);
    ext_st = {e[5], e[4], 17'h0, e[3], e[2], 6'h0, e[1], e[0], 3'h0};
  endfunction
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'h6CD6061A));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (roff[i])
    begin
      rdq(roff[i]);
      check("reset value", 32'h0, rd);
    end
    foreach (rsv[i])
    begin
      wr(rsv[i], $urandom);
      rdq(rsv[i]);
      check("reserved", 32'h0, rd);
    end
    a = $urandom;
    wr(dbu_pkg::OFF_MODE, a);
    rdq(dbu_pkg::OFF_MODE);
    check("mode", a & dbu_pkg::MODE_MASK, rd);
    wr(dbu_pkg::OFF_BAUD, a);
    rdq(dbu_pkg::OFF_BAUD);
    check("divisor", a & 32'hFFFF, rd);
    mask = 32'h0;
    repeat (16)
    begin
      a = $urandom;
      b = $urandom;
      f = 1'($urandom);
      ext <= 6'($urandom);
      dbg_rst_n <= 1'($urandom);
      wr(dbu_pkg::OFF_IEN, a);
      wr(dbu_pkg::OFF_IDIS, b);
      wr(dbu_pkg::OFF_DPB, {31'h0, f});
      mask = (mask | a) & ~b & dbu_pkg::IRQ_MASK;
      rdq(dbu_pkg::OFF_IMASK);
      check("mask", mask, rd);
      rdq(dbu_pkg::OFF_STAT);
      check("status", ext_st(ext), rd);
      check("irq", |(ext_st(ext) & mask), irq);
      check("test reset", !f && dbg_rst_n, tprst_n);
    end
    ext <= 6'h00;
    wr(dbu_pkg::OFF_BAUD, 32'h1);
    wr(dbu_pkg::OFF_CMD, 32'h50);
    rdq(dbu_pkg::OFF_STAT);
    check("enabled", 32'h202, rd);
    // Each pass covers one check-bit code and one channel mode
    for (int k = 0; k < 5; k++)
    begin
      p = 3'(k);
      a = $urandom & 32'hFF;
      b = $urandom & 32'hFF;
      c = (k % 4 == 0) ? b[7:0] : a[7:0];
      wr(dbu_pkg::OFF_MODE, 32'(k % 4) << dbu_pkg::MODE_CH_LSB | 32'(p) << dbu_pkg::MODE_PAR_LSB);
      fork
        term.send(a[7:0], !p[2], pbit(p, a[7:0]), 1'b1);
        wr(dbu_pkg::OFF_THR, b);
      join
      bits(2);
      rdq(dbu_pkg::OFF_STAT);
      check("rx status", k % 4 != 3, rd & 32'hE1);
      rdq(dbu_pkg::OFF_RHR);
      if (k % 4 != 3) check("rx char", k % 4 == 2 ? b : a, rd);
      rdq(dbu_pkg::OFF_STAT);
      check("rx taken", 0, rd[0]);
      check("line count", k % 4 != 2, term.got.size());
      if (k % 4 != 2) check("line char", {p[2] | pbit(p, c), c}, term.got[0]);
      term.got.delete();
    end
    wr(dbu_pkg::OFF_MODE, 32'h0);
    term.send(a[7:0], 1'b1, !pbit(3'h0, a[7:0]), 1'b0);
    term.send(b[7:0], 1'b1, pbit(3'h0, b[7:0]), 1'b1);
    bits(2);
    rdq(dbu_pkg::OFF_STAT);
    check("errors", 32'hE1, rd & 32'hE1);
    wr(dbu_pkg::OFF_CMD, 32'h100);
    rdq(dbu_pkg::OFF_STAT);
    check("errors cleared", 32'h1, rd & 32'hE1);
    rdq(dbu_pkg::OFF_RHR);
    check("rx char", b, rd);
    // Distinct characters so an aborted one cannot look complete
    for (int k = 0; k < 2; k++)
    begin
      c = k ? ~a[7:0] | 8'h01 : a[7:0] & 8'hFE;
      wr(dbu_pkg::OFF_CMD, 32'h10);
      fork
        term.send(c, 1'b1, pbit(3'h0, c), 1'b1);
        begin
          bits(4);
          wr(dbu_pkg::OFF_CMD, k ? 32'h4 : 32'h20);
        end
      join
      rdq(dbu_pkg::OFF_RHR);
      check("rx after stop", !k, rd[7:0] === c);
    end
    wr(dbu_pkg::OFF_THR, a);
    wr(dbu_pkg::OFF_THR, b);
    rdq(dbu_pkg::OFF_STAT);
    check("tx busy", 32'h0, rd & 32'h202);
    wr(dbu_pkg::OFF_CMD, 32'h80);
    bits(26);
    check("drained", 2, term.got.size());
    check("first char", {pbit(3'h0, a[7:0]), a[7:0]}, term.got[0]);
    check("second char", {pbit(3'h0, b[7:0]), b[7:0]}, term.got[1]);
    rdq(dbu_pkg::OFF_STAT);
    check("tx off", 32'h0, rd & 32'h202);
    wr(dbu_pkg::OFF_CMD, 32'h40);
    wr(dbu_pkg::OFF_THR, a);
    bits(4);
    wr(dbu_pkg::OFF_CMD, 32'h8);
    bits(8);
    wr(dbu_pkg::OFF_CMD, 32'hF0);
    term.send(b[7:0], 1'b1, pbit(3'h0, b[7:0]), 1'b1);
    rdq(dbu_pkg::OFF_STAT);
    check("stay off", 32'h0, rd & 32'h203);
    finish_test();
  end
endmodule // tb_debug_uart_register_interface
`default_nettype wire
